// [common/lindf_pkg.sv]
// Purpose: constants for the lin channel diagnostic flag logic
// Assumes: 100 MHz system clock, separate link clock
// Notes:   flag bit positions of the diagnostic flag word
// ----------------------------------------------------------------------
// Operation
// RL1: bus-clamp flag sets when the bus stays dominant past the timeout.
// RL2: bus-clamp flag clears only after recovery followed by a flag read.
// RL3: mode flag is 1 in transmit/receive mode and 0 otherwise.
// RL4: mode flag drops on a leave command or a forcing fault event.
// RL5: the flag read never clears the mode flag.
// RL6: wake-receiver flag is 1 in sleep with wake enabled, else 0.
// RL7: the flag read never clears the wake-receiver flag.
// RL8: wake-source flag sets on lin wake and clears on any flag read (the code keeps it set when lin wake is still present at the read).
// RL9: bus short-to-ground flag clears after recovery then a read.
// RL10: overtemperature flag clears after cooling then a read.
// RL11: receive-pin-low flag clears after recovery then a read.
// RL12: receive-pin-recessive flag clears after recovery then a read.
// RL13: transmit-pin-low flag clears after recovery then a read.
// RL14: a fault still present at the read keeps its flag set.
// RL15: the status word group bit shows lin as an event source.
// ----------------------------------------------------------------------
package lindf_pkg;
    // dominant timeout in microseconds, counted on the link clock
    localparam int DOM_TIMEOUT_US = 8;
    localparam int LINK_CLK_MHZ   = 31;
    localparam int DOM_CYCLES     = DOM_TIMEOUT_US * LINK_CLK_MHZ;
    localparam int FLAG_W         = 9;
    // flag word bit positions
    localparam int B_CLAMP   = 0;
    localparam int B_MODE    = 1;
    localparam int B_WAKERX  = 2;
    localparam int B_WAKESRC = 3;
    localparam int B_GND     = 4;
    localparam int B_OTEMP   = 5;
    localparam int B_RXLOW   = 6;
    localparam int B_RXREC   = 7;
    localparam int B_TXLOW   = 8;
    localparam logic [8:0] FLAG_RESET = 9'h000;
    typedef enum logic [1:0] {LINDF_OFF, LINDF_TRX, LINDF_SLEEP} lindf_mode_e;
endpackage

// [rtl/lindf_sticky.sv]
// Purpose: one latched fault flag with read-after-recovery clear
// Assumes: set and fault are synchronous to clk
// Notes:   set wins over a clear in the same cycle
module lindf_sticky (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // fault side
    input  wire logic set,
    input  wire logic fault,
    input  wire logic need_recover,
    // read side
    input  wire logic rd,
    output logic      flag
);
    logic armed;
    logic next_flag;
    logic next_armed;
    wire  clr_ok = rd && (!need_recover || armed) && !fault;

    assign next_flag  = set ? 1'b1 : (clr_ok ? 1'b0 : flag);
    assign next_armed = (flag && !fault && !set && !clr_ok) ? 1'b1 :
                        (fault || !flag) ? 1'b0 : armed;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag  <= 1'b0;
            armed <= 1'b0;
        end else begin
            flag  <= next_flag;
            armed <= next_armed;
        end
    end
endmodule

// [rtl/lindf_flags.sv]
// Purpose: lin channel diagnostic and status flags
// Assumes: fault detector inputs are asynchronous levels
// Notes:   bus level timed on link clock, result crossed to clk
module lindf_flags #(
    parameter int DOM_CYCLES = lindf_pkg::DOM_CYCLES
) (
    // clocks and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       link_clk,
    // link side
    input  wire logic       bus_dominant,
    // fault detector levels
    input  wire logic       bus_gnd_fault,
    input  wire logic       over_temp,
    input  wire logic       rx_low_fault,
    input  wire logic       rx_rec_fault,
    input  wire logic       tx_low_fault,
    input  wire logic       lin_wake,
    input  wire logic       transmit_stuck_dominant_event,
    // mode commands, one-cycle pulses on clk; wake_en is a level sampled with cmd_sleep
    input  wire logic       cmd_trx,
    input  wire logic       cmd_sleep,
    input  wire logic       cmd_off,
    input  wire logic       wake_en,
    // flag read pulse
    input  wire logic       flag_rd,
    // outputs
    output logic [8:0]      flags,
    output logic            lin_group
);
    // ------------------------------------------------------------------
    // link domain: dominant timer
    // ------------------------------------------------------------------
    logic        dom_s1, dom_s2;
    logic [15:0] dom_cnt;
    logic        clamp_l;
    logic        rst_l1, rst_l2;

    // local reset release for link domain
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_l1 <= 1'b1;
            rst_l2 <= 1'b1;
        end else begin
            rst_l1 <= 1'b0;
            rst_l2 <= rst_l1;
        end
    end

    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dom_s1 <= 1'b0;
            dom_s2 <= 1'b0;
        end else begin
            dom_s1 <= bus_dominant;
            dom_s2 <= dom_s1;
        end
    end

    // RL1 dominant timeout count
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dom_cnt <= 16'h0000;
            clamp_l <= 1'b0;
        end else if (rst_l2 || !dom_s2) begin
            dom_cnt <= 16'h0000;
            clamp_l <= 1'b0;
        end else if (dom_cnt >= 16'(DOM_CYCLES - 1)) begin
            clamp_l <= 1'b1;
        end else begin
            dom_cnt <= dom_cnt + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // synchronisers into clk
    // ------------------------------------------------------------------
    logic [6:0] sy1, sy2;
    wire  [6:0] raw = {transmit_stuck_dominant_event, lin_wake, tx_low_fault,
                       rx_rec_fault, rx_low_fault, over_temp, bus_gnd_fault};
    logic [1:0] clamp_sy;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sy1      <= 7'h00;
            sy2      <= 7'h00;
            clamp_sy <= 2'h0;
        end else begin
            sy1      <= raw;
            sy2      <= sy1;
            clamp_sy <= {clamp_sy[0], clamp_l};
        end
    end

    wire clamp_c = clamp_sy[1];
    wire gnd_c   = sy2[0];
    wire otmp_c  = sy2[1];
    wire rxl_c   = sy2[2];
    wire rxr_c   = sy2[3];
    wire txl_c   = sy2[4];
    wire wake_c  = sy2[5];
    wire stuck_c = sy2[6];

    // ------------------------------------------------------------------
    // channel mode
    // ------------------------------------------------------------------
    lindf_pkg::lindf_mode_e mode, next_mode;
    logic wake_en_q;
    always_comb begin
        next_mode = mode;
        case (mode)
            lindf_pkg::LINDF_TRX: begin
                // RL4 leave on fault or command
                if (stuck_c || cmd_off) next_mode = lindf_pkg::LINDF_OFF;
                else if (cmd_sleep) next_mode = lindf_pkg::LINDF_SLEEP;
            end
            lindf_pkg::LINDF_SLEEP: begin
                if (cmd_trx && !stuck_c) next_mode = lindf_pkg::LINDF_TRX;
                else if (cmd_off) next_mode = lindf_pkg::LINDF_OFF;
            end
            lindf_pkg::LINDF_OFF: begin
                if (cmd_trx && !stuck_c) next_mode = lindf_pkg::LINDF_TRX;
                else if (cmd_sleep) next_mode = lindf_pkg::LINDF_SLEEP;
            end
            default: next_mode = lindf_pkg::LINDF_OFF;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode      <= lindf_pkg::LINDF_OFF;
            wake_en_q <= 1'b0;
        end else begin
            mode <= next_mode;
            if (cmd_sleep) wake_en_q <= wake_en;
        end
    end

    // ------------------------------------------------------------------
    // latched flags
    // ------------------------------------------------------------------
    logic [6:0] lat;
    wire  [6:0] lat_fault = {txl_c, rxr_c, rxl_c, otmp_c, gnd_c, 1'b0,
                             clamp_c};
    wire  [6:0] lat_set   = {txl_c, rxr_c, rxl_c, otmp_c, gnd_c, wake_c,
                             clamp_c};
    wire  [6:0] lat_recov = 7'h7D;

    // RL2 RL9 RL10 RL11 RL12 RL13 RL14 recover then read
    // RL8 wake source clears on read alone
    for (genvar i = 0; i < 7; i++) begin : g_lat
        lindf_sticky u_sticky (
            .clk          (clk),
            .sys_rst      (sys_rst),
            .set          (lat_set[i]),
            .fault        (lat_fault[i]),
            .need_recover (lat_recov[i]),
            .rd           (flag_rd),
            .flag         (lat[i])
        );
    end

    // RL3 RL5 mode flag is live
    wire mode_live = (mode == lindf_pkg::LINDF_TRX);
    // RL6 RL7 wake receiver flag is live
    wire wakerx_live = (mode == lindf_pkg::LINDF_SLEEP) && wake_en_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags     <= lindf_pkg::FLAG_RESET;
            lin_group <= 1'b0;
        end else begin
            flags[lindf_pkg::B_CLAMP]   <= lat[0];
            flags[lindf_pkg::B_WAKESRC] <= lat[1];
            flags[lindf_pkg::B_GND]     <= lat[2];
            flags[lindf_pkg::B_OTEMP]   <= lat[3];
            flags[lindf_pkg::B_RXLOW]   <= lat[4];
            flags[lindf_pkg::B_RXREC]   <= lat[5];
            flags[lindf_pkg::B_TXLOW]   <= lat[6];
            flags[lindf_pkg::B_MODE]    <= mode_live;
            flags[lindf_pkg::B_WAKERX]  <= wakerx_live;
            // RL15 group bit
            lin_group <= |lat;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_mode_follows: assert property (@(posedge clk) disable iff (sys_rst)
        ##1 flags[lindf_pkg::B_MODE] == $past(mode_live)) // RL3
        else $error("mode flag wrong");
    a_stuck_drops: assert property (@(posedge clk) disable iff (sys_rst)
        stuck_c |-> ##2 !flags[lindf_pkg::B_MODE]) // RL4
        else $error("mode flag not dropped on fault");
    a_read_keeps_mode: assert property (@(posedge clk) disable iff (sys_rst)
        (flag_rd && mode_live && !stuck_c && !cmd_off && !cmd_sleep)
        |-> ##2 flags[lindf_pkg::B_MODE]) // RL5
        else $error("read cleared mode flag");
    a_wakerx_live: assert property (@(posedge clk) disable iff (sys_rst)
        ##1 flags[lindf_pkg::B_WAKERX] == $past(wakerx_live)) // RL6
        else $error("wake receiver flag wrong");
    a_wake_clears: assert property (@(posedge clk) disable iff (sys_rst)
        (flag_rd && !wake_c) |=> !lat[1]) // RL8
        else $error("wake source not cleared");
    a_fault_holds: assert property (@(posedge clk) disable iff (sys_rst)
        (otmp_c && flag_rd) |=> lat[3]) // RL14
        else $error("flag cleared under fault");
    a_gnd_sets: assert property (@(posedge clk) disable iff (sys_rst)
        gnd_c |-> ##2 flags[lindf_pkg::B_GND]) // RL9
        else $error("ground flag not set");
    a_group_bit: assert property (@(posedge clk) disable iff (sys_rst)
        ##1 lin_group == $past(|lat)) // RL15
        else $error("group bit wrong");
    a_clamp_sets: assert property (@(posedge clk) disable iff (sys_rst)
        clamp_c |-> ##2 flags[lindf_pkg::B_CLAMP]) // RL1
        else $error("clamp flag not set");
    a_clamp_holds: assert property (@(posedge clk) disable iff (sys_rst)
        (clamp_c && flag_rd) |=> lat[0]) // RL2
        else $error("clamp flag cleared under fault");
    a_otemp_sets: assert property (@(posedge clk) disable iff (sys_rst)
        otmp_c |-> ##2 flags[lindf_pkg::B_OTEMP]) // RL10
        else $error("overtemperature flag not set");
    a_rxlow_sets: assert property (@(posedge clk) disable iff (sys_rst)
        rxl_c |-> ##2 flags[lindf_pkg::B_RXLOW]) // RL11
        else $error("receive low flag not set");
    a_rxrec_sets: assert property (@(posedge clk) disable iff (sys_rst)
        rxr_c |-> ##2 flags[lindf_pkg::B_RXREC]) // RL12
        else $error("receive recessive flag not set");
    a_txlow_sets: assert property (@(posedge clk) disable iff (sys_rst)
        txl_c |-> ##2 flags[lindf_pkg::B_TXLOW]) // RL13
        else $error("transmit low flag not set");
    a_wake_sets: assert property (@(posedge clk) disable iff (sys_rst)
        wake_c |-> ##2 flags[lindf_pkg::B_WAKESRC]) // RL8
        else $error("wake source flag not set");
    a_wakerx_read: assert property (@(posedge clk) disable iff (sys_rst)
        (flag_rd && wakerx_live && !cmd_trx && !cmd_off && !cmd_sleep)
        |-> ##2 flags[lindf_pkg::B_WAKERX]) // RL7
        else $error("read cleared wake receiver flag");

    // ------------------------------------------------------------------
    // link domain checks
    // ------------------------------------------------------------------
    // clamp only stands while the bus was seen dominant
    a_clamp_bus: assert property (@(posedge link_clk) disable iff (sys_rst)
        clamp_l |-> $past(dom_s2)) // RL1
        else $error("clamp without dominant bus");
    // timer stops at its end point when the clamp rises
    a_clamp_count: assert property (@(posedge link_clk)
        disable iff (sys_rst)
        $rose(clamp_l) |-> dom_cnt == 16'(DOM_CYCLES - 1)) // RL1
        else $error("clamp raised at wrong count");
endmodule

// [tb/lindf_host_model.sv]
// Purpose: host side that reads the diagnostic flags
// Assumes: a flag read is one clk-wide pulse on flag_rd
// Notes:   waits out the two-cycle answer before returning
module lindf_host_model (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // read strobe towards the flag logic
    output logic      flag_rd
);
    timeunit 1ns;
    timeprecision 1ps;

    initial flag_rd = 1'b0;

    // ----------------------------------------------------------------
    // flag read access
    // ----------------------------------------------------------------
    // held off while in reset, a read there would be lost anyway
    task automatic do_read();
        while (sys_rst) @(posedge clk);
        @(posedge clk);
        flag_rd <= 1'b1;
        @(posedge clk);
        flag_rd <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
endmodule

// [tb/tb_top.sv]
// Purpose: self-checking bench for the lin diagnostic flag logic
// Assumes: short dominant timeout of 10 link clocks
// Notes:   inputs change by non-blocking assignment at clk edges
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int DOM = 10;
    logic       clk, link_clk, sys_rst, bus_dominant, lin_wake, stuck;
    logic       cmd_trx, cmd_sleep, cmd_off, wake_en;
    logic [4:0] flt;
    logic       flag_rd;
    logic [8:0] flags;
    logic       lin_group;
    int         err_total, total_checks, n;

    // ----------------------------------------------------------------
    // clocks, design and host
    // ----------------------------------------------------------------
    initial clk = 1'b0;
    initial link_clk = 1'b0;
    always #5 clk = ~clk;
    // link edges land on multiples of 16 ns, never on a rising clk edge
    always #16 link_clk = ~link_clk;

    lindf_flags #(.DOM_CYCLES(DOM)) DUT (
        .clk(clk), .sys_rst(sys_rst), .link_clk(link_clk),
        .bus_dominant(bus_dominant), .bus_gnd_fault(flt[0]),
        .over_temp(flt[1]), .rx_low_fault(flt[2]),
        .rx_rec_fault(flt[3]), .tx_low_fault(flt[4]),
        .lin_wake(lin_wake), .transmit_stuck_dominant_event(stuck),
        .cmd_trx(cmd_trx), .cmd_sleep(cmd_sleep), .cmd_off(cmd_off),
        .wake_en(wake_en), .flag_rd(flag_rd), .flags(flags),
        .lin_group(lin_group));

    lindf_host_model HOST (.clk(clk), .sys_rst(sys_rst), .flag_rd(flag_rd));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic tick(int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic chk(string what, logic exp, logic got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic cmd(logic t, logic s, logic o, logic we);
        @(posedge clk);
        cmd_trx <= t;
        cmd_sleep <= s;
        cmd_off <= o;
        wake_en <= we;
        @(posedge clk);
        cmd_trx <= 1'b0;
        cmd_sleep <= 1'b0;
        cmd_off <= 1'b0;
        tick(3);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {sys_rst, bus_dominant, lin_wake, stuck} = 4'h8;
        {cmd_trx, cmd_sleep, cmd_off, wake_en} = 4'h0;
        flt = 5'h00;
        tick(3);
        sys_rst <= 1'b0;
        tick(2);
        chk("flags after reset", 1'b1, flags === 9'h000);
        // latched pin, bus and overtemperature faults, read while present then after
        for (int i = 0; i < 5; i++) begin
            flt[i] <= 1'b1;
            tick(5);
            chk("fault flag set", 1'b1, flags[lindf_pkg::B_GND + i]);
            chk("group bit", 1'b1, lin_group);
            HOST.do_read();
            chk("flag kept", 1'b1, flags[lindf_pkg::B_GND + i]);
            flt[i] <= 1'b0;
            tick(6);
            chk("flag held unread", 1'b1, flags[lindf_pkg::B_GND + i]);
            HOST.do_read();
            chk("flag cleared", 1'b0, flags[lindf_pkg::B_GND + i]);
            chk("group bit idle", 1'b0, lin_group);
        end
        // bus clamp: quiet before the timeout, set after it
        bus_dominant <= 1'b1;
        tick(16);
        chk("clamp early", 1'b0, flags[lindf_pkg::B_CLAMP]);
        n = 0;
        while (flags[lindf_pkg::B_CLAMP] !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        chk("clamp set", 1'b1, flags[lindf_pkg::B_CLAMP]);
        HOST.do_read();
        chk("clamp kept", 1'b1, flags[lindf_pkg::B_CLAMP]);
        bus_dominant <= 1'b0;
        // two link syncs, the timer clear and two clk syncs take ~130 ns
        tick(16);
        HOST.do_read();
        chk("clamp cleared", 1'b0, flags[lindf_pkg::B_CLAMP]);
        // wake source clears on a plain read
        lin_wake <= 1'b1;
        tick(3);
        lin_wake <= 1'b0;
        tick(4);
        chk("wake source set", 1'b1, flags[lindf_pkg::B_WAKESRC]);
        HOST.do_read();
        chk("wake source cleared", 1'b0, flags[lindf_pkg::B_WAKESRC]);
        // live mode and wake-receiver flags
        cmd(1'b1, 1'b0, 1'b0, 1'b0);
        chk("mode in trx", 1'b1, flags[lindf_pkg::B_MODE]);
        HOST.do_read();
        chk("mode survives read", 1'b1, flags[lindf_pkg::B_MODE]);
        cmd(1'b0, 1'b1, 1'b0, 1'b1);
        chk("mode in sleep", 1'b0, flags[lindf_pkg::B_MODE]);
        chk("wake rx enabled", 1'b1, flags[lindf_pkg::B_WAKERX]);
        HOST.do_read();
        chk("wake rx survives read", 1'b1, flags[lindf_pkg::B_WAKERX]);
        cmd(1'b0, 1'b1, 1'b0, 1'b0);
        chk("wake rx disabled", 1'b0, flags[lindf_pkg::B_WAKERX]);
        cmd(1'b1, 1'b0, 1'b0, 1'b0);
        cmd(1'b0, 1'b0, 1'b1, 1'b0);
        chk("mode after off", 1'b0, flags[lindf_pkg::B_MODE]);
        cmd(1'b1, 1'b0, 1'b0, 1'b0);
        stuck <= 1'b1;
        tick(5);
        chk("mode forced out", 1'b0, flags[lindf_pkg::B_MODE]);
        stuck <= 1'b0;
        tick(3);
        tally_and_finish();
    end
endmodule
